// ==== svo_pkg.sv ====
// Constants, register map and carrier types of the servo status outputs.
// Assumes a 10 MHz control clock and AXI4-Lite register access.
// Function
// - Ready only when runnable and fault free.
// - Power flag follows control power, regardless faults.
// - Zero speed while speed within threshold.
// - Default zero speed threshold is 10 RPM.
// - Target speed held while speed reaches target.
// - In position only in position control mode.
// - Torque flag when any limit is reached.
// - Alarm flag on any fault; warning-class faults one cycle late.
// - Five fault kinds raise warning before alarm.
// - Warning on limit, stop, link, undervoltage.
// - Brake flag follows brake actuation request.
// - Overload flag at configured overload level.
// - Slot state depends on assignment settings.
// - Any function assignable to any slot.
package svo_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int ADDR_W = 8;
  localparam int NFLAG = 10;

  localparam logic [7:0] OFF_ZERO_SPD = 8'h00;
  localparam logic [7:0] OFF_TGT_SPD = 8'h04;
  localparam logic [7:0] OFF_INPOS = 8'h08;
  localparam logic [7:0] OFF_TRQ_LIM0 = 8'h0C;
  localparam logic [7:0] OFF_TRQ_LIM1 = 8'h10;
  localparam logic [7:0] OFF_TRQ_LIM2 = 8'h14;
  localparam logic [7:0] OFF_OVL = 8'h18;
  localparam logic [7:0] OFF_SLOT = 8'h1C;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  localparam logic [7:0] OFF_ISTAT = 8'h24;
  localparam logic [7:0] OFF_IMASK = 8'h28;

  localparam logic [15:0] RST_ZERO_SPD = 16'h000A;
  localparam logic [15:0] RST_TGT_SPD = 16'h01F4;
  localparam logic [31:0] RST_INPOS = 32'h0000_0064;
  localparam logic [15:0] RST_TRQ_LIM = 16'h0064;
  localparam logic [15:0] RST_OVL = 16'h0078;
  localparam logic [18:0] RST_SLOT = 19'h0_0731;
  localparam logic [9:0] RST_IMASK = 10'h000;

  // Flag bit positions; a slot function code is the position plus one.
  localparam int F_READY = 0;
  localparam int F_POWER = 1;
  localparam int F_ZERO_SPD = 2;
  localparam int F_TGT_SPD = 3;
  localparam int F_INPOS = 4;
  localparam int F_TRQ_LIM = 5;
  localparam int F_ALARM = 6;
  localparam int F_BRAKE = 7;
  localparam int F_OVERLOAD = 8;
  localparam int F_WARN = 9;

  // Slot field layout: three 4-bit function codes, then invert bits.
  localparam int SLOT_FN_W = 4;
  localparam int SLOT_INV_LSB = 16;
  localparam int NSLOT = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ctrl_power;
    logic able_to_run;
    logic pos_mode;
    logic brake_req;
    logic [7:0] faults;
    logic signed [15:0] speed;
    logic signed [15:0] torque;
    logic [15:0] load;
    logic signed [31:0] pos_err;
  } svo_drive_s;

  typedef struct packed {
    logic warning_flag;
    logic overload_warning_flag;
    logic brake_control_flag;
    logic fault_alarm_flag;
    logic torque_limit_reached_flag;
    logic in_position_flag;
    logic target_speed_flag;
    logic zero_speed_flag;
    logic control_power_on_flag;
    logic drive_ready_flag;
  } svo_flags_s;

endpackage

// ==== svo_slot_map.sv ====
// Maps status flags onto the physical output slots.
// Assumes flags and configuration are on the same clock.
`timescale 1ns/1ps
`default_nettype none
module svo_slot_map import svo_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NFLAG-1:0] flags,
  input wire logic [18:0] slot_cfg,
  output var logic [NSLOT-1:0] slots_r
);

  logic [NSLOT-1:0] slots_nxt;

  // Code zero picks 0 for a slot ahead of its invert bit; unused codes also pick 0.
  function automatic logic pick(input logic [NFLAG-1:0] f,
                                input logic [3:0] code);
    logic r;
    r = 1'b0;
    if (code != 4'h0 && code <= 4'(NFLAG)) begin
      r = f[code - 4'h1];
    end
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < NSLOT; i++) begin
      slots_nxt[i] = pick(flags, slot_cfg[i*SLOT_FN_W +: SLOT_FN_W])
                     ^ slot_cfg[SLOT_INV_LSB + i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slots_r <= '0;
    end else begin
      slots_r <= slots_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== svo_status_outputs.sv ====
// Servo status outputs: flag generation, output slots, AXI4-Lite
// registers and interrupt. Drive state arrives on the same clock.
`timescale 1ns/1ps
`default_nettype none
module svo_status_outputs import svo_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire svo_drive_s drv,
  output var svo_flags_s status_flags,
  output var logic output_slot_one,
  output var logic output_slot_two,
  output var logic output_slot_three,
  output var logic irq
);

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Configuration, flag, interrupt and warning-delay registers.
  logic [15:0] zero_thr_r;
  logic [15:0] tgt_spd_r;
  logic [31:0] inpos_r;
  logic [15:0] trq_lim0_r;
  logic [15:0] trq_lim1_r;
  logic [15:0] trq_lim2_r;
  logic [15:0] ovl_r;
  logic [18:0] slot_r;
  logic [NFLAG-1:0] imask_r;
  logic [NFLAG-1:0] istat_r;
  logic [NFLAG-1:0] istat_nxt;
  logic [NFLAG-1:0] flags_r;
  logic [NFLAG-1:0] flags_nxt;
  logic warn_d_r;
  logic irq_r;

  // Bus handshake state.
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Flag evaluation.
  wire [15:0] spd_abs = mag16(drv.speed);
  wire [15:0] tq_abs = mag16(drv.torque);
  wire [31:0] perr_abs = drv.pos_err[31] ? 32'(-drv.pos_err)
                                         : 32'(drv.pos_err);
  wire warn_now = |drv.faults[4:0];
  wire other_fault = |drv.faults[7:5];
  // The five warning-class faults reach the alarm one cycle late.
  wire alarm_now = other_fault | (warn_now & warn_d_r);
  wire zero_now = spd_abs <= zero_thr_r;
  wire tgt_now = spd_abs >= tgt_spd_r;
  wire inpos_now = drv.pos_mode & (perr_abs <= inpos_r);
  wire trq_now = (tq_abs >= trq_lim0_r) | (tq_abs >= trq_lim1_r)
                 | (tq_abs >= trq_lim2_r);
  wire ovl_now = drv.load >= ovl_r;
  wire ready_now = drv.ctrl_power & drv.able_to_run
                   & ~warn_now & ~other_fault;

  always_comb begin
    flags_nxt = '0;
    flags_nxt[F_READY] = ready_now;
    flags_nxt[F_POWER] = drv.ctrl_power;
    flags_nxt[F_ZERO_SPD] = zero_now;
    flags_nxt[F_TGT_SPD] = tgt_now;
    flags_nxt[F_INPOS] = inpos_now;
    flags_nxt[F_TRQ_LIM] = trq_now;
    flags_nxt[F_ALARM] = alarm_now;
    flags_nxt[F_BRAKE] = drv.brake_req;
    flags_nxt[F_OVERLOAD] = ovl_now;
    flags_nxt[F_WARN] = warn_now;
  end

  // Write channel: address and data are taken in the same cycle.
  wire wr_take = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
  wire wr_fire = awready_r & wready_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  wire sel_zero = waddr_r == OFF_ZERO_SPD;
  wire sel_tgt = waddr_r == OFF_TGT_SPD;
  wire sel_inpos = waddr_r == OFF_INPOS;
  wire sel_lim0 = waddr_r == OFF_TRQ_LIM0;
  wire sel_lim1 = waddr_r == OFF_TRQ_LIM1;
  wire sel_lim2 = waddr_r == OFF_TRQ_LIM2;
  wire sel_ovl = waddr_r == OFF_OVL;
  wire sel_slot = waddr_r == OFF_SLOT;
  wire sel_imask = waddr_r == OFF_IMASK;
  wire wr_ro = (waddr_r == OFF_FLAGS) | (waddr_r == OFF_ISTAT);
  wire wr_ok = sel_zero | sel_tgt | sel_inpos | sel_lim0 | sel_lim1
               | sel_lim2 | sel_ovl | sel_slot | sel_imask | wr_ro;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      awready_r <= wr_take;
      wready_r <= wr_take;
      if (wr_take) begin
        waddr_r <= s_axi_awaddr;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Each register merges its byte lanes from the latched write data.
  wire [31:0] wr_zero = merge({16'h0, zero_thr_r}, wdata_r, wstrb_r);
  wire [31:0] wr_tgt = merge({16'h0, tgt_spd_r}, wdata_r, wstrb_r);
  wire [31:0] wr_inpos = merge(inpos_r, wdata_r, wstrb_r);
  wire [31:0] wr_lim0 = merge({16'h0, trq_lim0_r}, wdata_r, wstrb_r);
  wire [31:0] wr_lim1 = merge({16'h0, trq_lim1_r}, wdata_r, wstrb_r);
  wire [31:0] wr_lim2 = merge({16'h0, trq_lim2_r}, wdata_r, wstrb_r);
  wire [31:0] wr_ovl = merge({16'h0, ovl_r}, wdata_r, wstrb_r);
  wire [31:0] wr_slot = merge({13'h0, slot_r}, wdata_r, wstrb_r);
  wire [31:0] wr_imask = merge({22'h0, imask_r}, wdata_r, wstrb_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_thr_r <= RST_ZERO_SPD;
    end else if (wr_fire && sel_zero) begin
      zero_thr_r <= wr_zero[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgt_spd_r <= RST_TGT_SPD;
    end else if (wr_fire && sel_tgt) begin
      tgt_spd_r <= wr_tgt[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inpos_r <= RST_INPOS;
    end else if (wr_fire && sel_inpos) begin
      inpos_r <= wr_inpos;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trq_lim0_r <= RST_TRQ_LIM;
    end else if (wr_fire && sel_lim0) begin
      trq_lim0_r <= wr_lim0[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trq_lim1_r <= RST_TRQ_LIM;
    end else if (wr_fire && sel_lim1) begin
      trq_lim1_r <= wr_lim1[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trq_lim2_r <= RST_TRQ_LIM;
    end else if (wr_fire && sel_lim2) begin
      trq_lim2_r <= wr_lim2[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovl_r <= RST_OVL;
    end else if (wr_fire && sel_ovl) begin
      ovl_r <= wr_ovl[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_r <= RST_SLOT;
    end else if (wr_fire && sel_slot) begin
      slot_r <= wr_slot[18:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imask_r <= RST_IMASK;
    end else if (wr_fire && sel_imask) begin
      imask_r <= wr_imask[NFLAG-1:0];
    end
  end

  // Read channel.
  wire rd_take = s_axi_arvalid & ~arready_r & ~rvalid_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = RESP_OKAY;
    if (s_axi_araddr == OFF_ZERO_SPD) begin
      rdata_nxt = {16'h0, zero_thr_r};
    end else if (s_axi_araddr == OFF_TGT_SPD) begin
      rdata_nxt = {16'h0, tgt_spd_r};
    end else if (s_axi_araddr == OFF_INPOS) begin
      rdata_nxt = inpos_r;
    end else if (s_axi_araddr == OFF_TRQ_LIM0) begin
      rdata_nxt = {16'h0, trq_lim0_r};
    end else if (s_axi_araddr == OFF_TRQ_LIM1) begin
      rdata_nxt = {16'h0, trq_lim1_r};
    end else if (s_axi_araddr == OFF_TRQ_LIM2) begin
      rdata_nxt = {16'h0, trq_lim2_r};
    end else if (s_axi_araddr == OFF_OVL) begin
      rdata_nxt = {16'h0, ovl_r};
    end else if (s_axi_araddr == OFF_SLOT) begin
      rdata_nxt = {13'h0, slot_r};
    end else if (s_axi_araddr == OFF_FLAGS) begin
      rdata_nxt = {22'h0, flags_r};
    end else if (s_axi_araddr == OFF_ISTAT) begin
      rdata_nxt = {22'h0, istat_r};
    end else if (s_axi_araddr == OFF_IMASK) begin
      rdata_nxt = {22'h0, imask_r};
    end else begin
      rresp_nxt = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= rd_take;
      if (rd_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rdata_nxt;
        rresp_r <= rresp_nxt;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Interrupts: each flag's rising edge is sticky; reading clears it,
  // but an edge in the clearing cycle survives.
  wire istat_clr = rd_take & (s_axi_araddr == OFF_ISTAT);
  wire [NFLAG-1:0] rise = flags_nxt & ~flags_r;

  always_comb begin
    istat_nxt = (istat_r & ~{NFLAG{istat_clr}}) | rise;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_r <= |(istat_nxt & imask_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= '0;
      warn_d_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      warn_d_r <= warn_now;
    end
  end

  logic [NSLOT-1:0] slots;

  svo_slot_map u_slots (
    .aclk(aclk),
    .aresetn(aresetn),
    .flags(flags_nxt),
    .slot_cfg(slot_r),
    .slots_r(slots)
  );

  assign output_slot_one = slots[0];
  assign output_slot_two = slots[1];
  assign output_slot_three = slots[2];
  assign status_flags = svo_flags_s'(flags_r);
  assign irq = irq_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

// ==== svo_status_outputs_monitor.sv ====
// Concurrent checks on the status flags of the servo status outputs.
// Assumes default threshold settings apart from extra torque limits.
`timescale 1ns/1ps
`default_nettype none
module svo_status_outputs_monitor import svo_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire svo_drive_s drv,
  input wire svo_flags_s status_flags
);
  wire logic [15:0] spd_m = drv.speed[15] ? -drv.speed : drv.speed;
  wire logic [15:0] trq_m = drv.torque[15] ? -drv.torque : drv.torque;
  wire logic rdy_c = drv.ctrl_power & drv.able_to_run & ~|drv.faults;
  wire logic pw_c = drv.ctrl_power;
  wire logic bk_c = drv.brake_req;
  wire logic pm_c = drv.pos_mode;
  wire logic zs_c = spd_m <= RST_ZERO_SPD;
  wire logic tq_c = trq_m >= RST_TRQ_LIM;
  wire logic ol_c = drv.load >= RST_OVL;
  wire logic wn_c = |drv.faults[4:0];
  wire logic ot_c = |drv.faults[7:5];
  wire logic al = status_flags.fault_alarm_flag;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_ready_gate: assert property ($past(aresetn) |->
    status_flags.drive_ready_flag == $past(rdy_c)) else $error("ready");
  a_power_follow: assert property ($past(aresetn) |->
    status_flags.control_power_on_flag == $past(pw_c)) else $error("power");
  a_zero_speed: assert property ($past(aresetn) |->
    status_flags.zero_speed_flag == $past(zs_c)) else $error("zero speed");
  a_inpos_mode: assert property ($past(aresetn) && !$past(pm_c) |->
    !status_flags.in_position_flag) else $error("in position");
  a_torque_lim: assert property ($past(aresetn) && $past(tq_c) |->
    status_flags.torque_limit_reached_flag) else $error("torque limit");
  a_alarm_fault: assert property ($past(aresetn) && $past(ot_c) |->
    al) else $error("alarm");
  a_warn_first: assert property ($rose(status_flags.warning_flag) &&
    !$past(ot_c) && !$past(al) |-> !al ##1 al) else $error("warn order");
  a_warn_cause: assert property ($past(aresetn) |->
    status_flags.warning_flag == $past(wn_c)) else $error("warning");
  a_brake_follow: assert property ($past(aresetn) |->
    status_flags.brake_control_flag == $past(bk_c)) else $error("brake");
  a_overload_lvl: assert property ($past(aresetn) |->
    status_flags.overload_warning_flag == $past(ol_c)) else $error("load");
  c_warn: cover property ($rose(status_flags.warning_flag));
  c_alarm: cover property ($rose(al));
  c_inpos: cover property ($rose(status_flags.in_position_flag));
endmodule
bind svo_status_outputs svo_status_outputs_monitor u_mon (.aclk, .aresetn,
  .drv, .status_flags);
`default_nettype wire

// ==== svo_ctrl_model.sv ====
// Motion controller side: latches the three discrete output slots.
// Assumes the slots are sampled on the drive clock.
`timescale 1ns/1ps
`default_nettype none
module svo_ctrl_model (
  input wire logic aclk,
  input wire logic [2:0] slots,
  output var logic [2:0] seen_r
);
  always_ff @(posedge aclk) begin
    seen_r <= slots;
  end
endmodule
`default_nettype wire

// ==== tb_svo_status_outputs.sv ====
// Self-checking bench for the servo status outputs.
// Assumes the package, the design, its monitor and the controller model.
`timescale 1ns/1ps
`default_nettype none
module tb_svo_status_outputs import svo_pkg::*; ();
  // Bit c is the flag seen at function code c while the flags read 0x087.
  localparam logic [15:0] SLOT_PAT = 16'h010E;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, output_slot_one, output_slot_two, output_slot_three;
  logic irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] ctrl_seen;
  svo_flags_s status_flags;
  svo_drive_s drv = '0, d = '0;
  int n_mismatch = 0, samples_checked = 0;
  int sp[8] = '{10, 11, -10, -11, 0, 499, 500, -500};
  always #50 aclk = ~aclk;
  svo_status_outputs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .drv, .status_flags, .output_slot_one,
    .output_slot_two, .output_slot_three, .irq);
  svo_ctrl_model u_ctrl (.aclk, .seen_r(ctrl_seen),
    .slots({output_slot_three, output_slot_two, output_slot_one}));
  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic c1(string nm, logic s, logic e);
    chk(nm, {31'h0, s}, {31'h0, e});
  endtask
  task automatic wait_hi(ref logic s);
    for (int n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s === 1'b1) return;
    end
    n_mismatch++;
    end_of_test();
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] w, output logic [1:0] rs);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, w};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    wait_hi(s_axi_awready);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    wait_hi(s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e,
                      logic [1:0] er);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    if (s_axi_rvalid !== 1'b1) wait_hi(s_axi_rvalid);
    chk(nm, s_axi_rdata, e);
    chk(nm, {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  task automatic apply();
    @(posedge aclk);
    drv <= d;
    repeat (2) @(negedge aclk);
  endtask
  task automatic cf(string nm, logic [31:0] e);
    chk(nm, {22'h0, status_flags}, e);
  endtask
  task automatic flag(string nm, int b, logic e);
    apply();
    c1(nm, status_flags[b], e);
  endtask
  task automatic t_regs();
    rchk("zero_thr", OFF_ZERO_SPD, 32'h0000_000A, RESP_OKAY);
    rchk("tgt_set", OFF_TGT_SPD, 32'h0000_01F4, RESP_OKAY);
    rchk("slot_cfg", OFF_SLOT, 32'h0000_0731, RESP_OKAY);
    rchk("unmapped", 8'h2C, 32'h0000_0000, RESP_SLVERR);
    wr(8'h2C, 32'h0000_0001, r);
    chk("wr_unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_flags();
    d.ctrl_power = 1'b1;
    apply();
    cf("power_only", 32'h0000_0006);
    d.able_to_run = 1'b1;
    apply();
    cf("ready", 32'h0000_0007);
    d.brake_req = 1'b1;
    d.faults = 8'h80;
    apply();
    cf("other_fault", 32'h0000_00C6);
    d.faults = 8'h00;
    apply();
    cf("cleared", 32'h0000_0087);
  endtask
  task automatic t_warn();
    for (int i = 0; i < 5; i++) begin
      d.faults = 8'h01 << i;
      apply();
      cf("warn_first", 32'h0000_0286);
      @(negedge aclk);
      cf("warn_alarm", 32'h0000_02C6);
      d.faults = 8'h00;
      apply();
    end
  endtask
  task automatic t_speed();
    int a;
    for (int i = 0; i < 8; i++) begin
      d.speed = 16'(sp[i]);
      a = sp[i] < 0 ? -sp[i] : sp[i];
      flag("zero_spd", F_ZERO_SPD, a <= 10);
      c1("tgt_spd", status_flags[F_TGT_SPD], a >= 500);
    end
  endtask
  task automatic t_misc();
    d.pos_err = 32'h0000_0064;
    flag("inpos_mode", F_INPOS, 1'b0);
    d.pos_mode = 1'b1;
    flag("inpos_edge", F_INPOS, 1'b1);
    d.pos_err = 32'h0000_0065;
    flag("inpos_out", F_INPOS, 1'b0);
    d.torque = 16'hFF9C;
    flag("trq_neg", F_TRQ_LIM, 1'b1);
    d.torque = 16'h0030;
    flag("trq_low", F_TRQ_LIM, 1'b0);
    wr(OFF_TRQ_LIM1, 32'h0000_0020, r);
    chk("wr_okay", {30'h0, r}, {30'h0, RESP_OKAY});
    flag("trq_any", F_TRQ_LIM, 1'b1);
    d.load = 16'h0077;
    flag("load_low", F_OVERLOAD, 1'b0);
    d.load = 16'h0078;
    flag("load_at", F_OVERLOAD, 1'b1);
  endtask
  task automatic t_slots();
    d = '0;
    d.ctrl_power = 1'b1;
    d.able_to_run = 1'b1;
    d.brake_req = 1'b1;
    apply();
    for (int c = 0; c < 16; c++) begin
      wr(OFF_SLOT, {13'h0, 3'h4, 4'h0, 4'(c), 4'(c), 4'(c)}, r);
      repeat (2) @(negedge aclk);
      c1("slot1", output_slot_one, SLOT_PAT[c]);
      c1("slot2", output_slot_two, SLOT_PAT[c]);
      c1("slot3", output_slot_three, !SLOT_PAT[c]);
    end
    wr(OFF_SLOT, 32'h0000_0731, r);
    wr(OFF_FLAGS, 32'hFFFF_FFFF, r);
    rchk("flags_reg", OFF_FLAGS, 32'h0000_0087, RESP_OKAY);
    chk("ctrl_view", {29'h0, ctrl_seen}, 32'h0000_0003);
  endtask
  task automatic t_irq();
    d.brake_req = 1'b0;
    wr(OFF_IMASK, 32'h0000_0080, r);
    apply();
    rchk("istat_old", OFF_ISTAT, 32'h0000_03FF, RESP_OKAY);
    repeat (2) @(negedge aclk);
    c1("irq_idle", irq, 1'b0);
    d.brake_req = 1'b1;
    apply();
    wait_hi(irq);
    rchk("istat", OFF_ISTAT, 32'h0000_0080, RESP_OKAY);
    repeat (2) @(negedge aclk);
    c1("irq_clr", irq, 1'b0);
    wr(OFF_IMASK, 32'h0000_0000, r);
    d.brake_req = 1'b0;
    apply();
    d.brake_req = 1'b1;
    apply();
    c1("irq_mask", irq, 1'b0);
    rchk("istat_m", OFF_ISTAT, 32'h0000_0080, RESP_OKAY);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_flags();
    t_warn();
    t_speed();
    t_misc();
    t_slots();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
